/* File: bench/colour_lut_dither_sva.sv */
`timescale 1ns/1ps
module colour_lut_dither_sva (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RSTN,
    // Register port
    input wire logic       REG_WE,
    input wire logic       REG_RE,
    input wire logic [3:0] REG_PAGE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic [7:0] NEXT_SUBADDR,
    // Pixel ports
    input wire logic       PIX_VALID,
    input wire logic       PIX_READY,
    input wire logic       OUT_VALID,
    input wire logic       OUT_READY,
    input wire logic [7:0] OUT_R,
    input wire logic [7:0] OUT_G,
    input wire logic [7:0] OUT_B
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    logic [7:0] ctl_q;
    logic       low_wr;
    logic       ctl_wr;

    assign low_wr = REG_WE && REG_PAGE == 4'h0 && REG_ADDR == 8'h03;
    assign ctl_wr = REG_WE && REG_PAGE == 4'h0 && REG_ADDR == 8'h01;

    // Shadow of the table control, so quick repeat can be predicted
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ctl_q <= 8'h00;
        end else if (ctl_wr) begin
            ctl_q <= REG_WDATA;
        end
    end

    a_reset_clears: assert property (disable iff (1'b0) !RSTN |=>
        OUT_VALID == 1'b0 && REG_RDATA == 8'h00 && NEXT_SUBADDR == 8'h00 && PIX_READY)
        else $error("outputs not cleared by reset");
    a_subaddr_wrap: assert property (low_wr |=>
        NEXT_SUBADDR == ($past(ctl_q[4]) ? 8'h03 : 8'h02))
        else $error("wrong subaddress after low byte write");
    a_subaddr_step: assert property (REG_WE && !low_wr |=>
        NEXT_SUBADDR == $past(REG_ADDR) + 8'h01)
        else $error("subaddress did not step by one");
    a_subaddr_hold: assert property (!REG_WE && !REG_RE |=> $stable(NEXT_SUBADDR))
        else $error("subaddress changed without strobe");
    a_ctrl_readback: assert property (REG_RE && REG_PAGE == 4'h0 && REG_ADDR == 8'h01 |=>
        REG_RDATA == $past(ctl_q))
        else $error("control read back wrong");
    a_unmapped_read: assert property (REG_RE && REG_PAGE != 4'h0 && REG_PAGE != 4'ha |=>
        REG_RDATA == 8'h00)
        else $error("unmapped page read not zero");
    a_rdata_hold: assert property (!REG_RE |=> $stable(REG_RDATA))
        else $error("read data changed without read");
    a_out_hold: assert property (OUT_VALID && !OUT_READY |=>
        OUT_VALID && $stable({OUT_R, OUT_G, OUT_B}))
        else $error("output word changed while stalled");
    a_pix_latency: assert property (PIX_VALID && PIX_READY && !OUT_VALID |-> ##3 OUT_VALID)
        else $error("pixel late at output");
    a_ready_empty: assert property (!OUT_VALID |-> PIX_READY)
        else $error("input refused with empty buffer");

    c_quick: cover property (low_wr && ctl_q[4]);
    c_refuse: cover property (PIX_VALID && !PIX_READY);
    c_stall: cover property (OUT_VALID && !OUT_READY ##1 OUT_VALID && OUT_READY);
endmodule

bind colour_lut_dither colour_lut_dither_sva u_colour_lut_dither_sva (
    .CLOCK(CLOCK), .RSTN(RSTN), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_PAGE(REG_PAGE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .NEXT_SUBADDR(NEXT_SUBADDR), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_R(OUT_R), .OUT_G(OUT_G),
    .OUT_B(OUT_B)
);

/* File: bench/pixel_sink.sv */
`timescale 1ns/1ps
module pixel_sink (
    // Clock and flow control
    input  wire logic       clk,
    input  wire logic       stall,
    // Pixel output of the block
    input  wire logic       out_valid,
    output logic            out_ready,
    input  wire logic [7:0] out_r,
    input  wire logic [7:0] out_g,
    input  wire logic [7:0] out_b
);
    logic [23:0] got[$];

    // Panel side may hold off the block for any number of cycles
    assign out_ready = !stall;

    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            got.push_back({out_r, out_g, out_b});
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic       CLOCK, RSTN, REG_WE, REG_RE, PIX_VALID, PIX_READY, PIX_LINE_START;
    logic       PIX_FRAME_START, PIX_HBLANK, OUT_VALID, OUT_READY, stall, refused;
    logic [3:0] REG_PAGE;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, NEXT_SUBADDR, PIX_R, PIX_G, PIX_B;
    logic [7:0] OUT_R, OUT_G, OUT_B;
    int         failures, tests_run, i;

    colour_lut_dither u_colour_lut_dither (
        .CLOCK(CLOCK), .RSTN(RSTN), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_PAGE(REG_PAGE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .NEXT_SUBADDR(NEXT_SUBADDR), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
        .PIX_R(PIX_R), .PIX_G(PIX_G), .PIX_B(PIX_B), .PIX_LINE_START(PIX_LINE_START),
        .PIX_FRAME_START(PIX_FRAME_START), .PIX_HBLANK(PIX_HBLANK), .OUT_VALID(OUT_VALID),
        .OUT_READY(OUT_READY), .OUT_R(OUT_R), .OUT_G(OUT_G), .OUT_B(OUT_B)
    );

    pixel_sink u_pixel_sink (
        .clk(CLOCK), .stall(stall), .out_valid(OUT_VALID), .out_ready(OUT_READY),
        .out_r(OUT_R), .out_g(OUT_G), .out_b(OUT_B)
    );

    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic stop_test();
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Write strobe drops for one edge so no signal is driven twice in a step
    task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
        REG_WE <= 1'b1;
        REG_PAGE <= pg;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLOCK);
        REG_WE <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic rd(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] e);
        REG_RE <= 1'b1;
        REG_PAGE <= pg;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RE <= 1'b0;
        @(posedge CLOCK);
        check({16'h0000, REG_RDATA}, {16'h0000, e}, "read");
    endtask

    task automatic pix(input logic [23:0] p);
        PIX_VALID <= 1'b1;
        {PIX_R, PIX_G, PIX_B} <= p;
        @(posedge CLOCK);
        while (PIX_READY !== 1'b1) begin
            refused = 1'b1;
            @(posedge CLOCK);
        end
    endtask

    task automatic pix_idle();
        PIX_VALID <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic expect_pix(input logic [23:0] e);
        logic [23:0] g;
        repeat (300) if (u_pixel_sink.got.size() == 0) @(posedge CLOCK);
        g = (u_pixel_sink.got.size() != 0) ? u_pixel_sink.got.pop_front() : 24'hxxxxxx;
        check(g, e, "pixel");
    endtask

    task automatic one(input logic [23:0] p, input logic [23:0] e);
        pix(p);
        pix_idle();
        expect_pix(e);
    endtask

    initial begin
        repeat (20000) @(posedge CLOCK);
        failures++;
        stop_test();
    end

    initial begin
        {RSTN, REG_WE, REG_RE, PIX_VALID, PIX_LINE_START, PIX_FRAME_START} = 6'h00;
        {PIX_HBLANK, stall, refused} = 3'h0;
        {REG_PAGE, REG_ADDR, REG_WDATA} = 20'h00000;
        {PIX_R, PIX_G, PIX_B} = 24'h000000;
        failures = 0;
        tests_run = 0;
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
        check({16'h0000, NEXT_SUBADDR}, 24'h000000, "subaddr");
        rd(4'h0, 8'h01, 8'h00);
        rd(4'ha, 8'h80, 8'h01);
        rd(4'ha, 8'h81, 8'h00);
        rd(4'ha, 8'h82, 8'h00);
        rd(4'ha, 8'h83, 8'h00);
        wr(4'h5, 8'h01, 8'hff);
        rd(4'h5, 8'h01, 8'h00);
        one(24'hab4003, 24'h2a1000);
        wr(4'h0, 8'h00, 8'h10);
        wr(4'h0, 8'h01, 8'h1f);
        wr(4'h0, 8'h02, 8'h03);
        wr(4'h0, 8'h03, 8'h55);
        check({16'h0000, NEXT_SUBADDR}, 24'h000003, "quick");
        wr(4'h0, 8'h03, 8'h66);
        wr(4'h0, 8'h01, 8'h03);
        rd(4'h0, 8'h01, 8'h03);
        wr(4'h0, 8'h00, 8'h10);
        wr(4'h0, 8'h02, 8'h01);
        wr(4'h0, 8'h03, 8'h22);
        check({16'h0000, NEXT_SUBADDR}, 24'h000002, "wrap");
        wr(4'ha, 8'h80, 8'h03);
        pix(24'h101010);
        pix(24'h111111);
        pix_idle();
        expect_pix(24'h48d5d5);
        expect_pix(24'hd9d9d9);
        wr(4'ha, 8'h80, 8'h01);
        one(24'h101010, 24'h123535);
        wr(4'h0, 8'h01, 8'h00);
        wr(4'ha, 8'h80, 8'h03);
        one(24'h10c711, 24'h10c711);
        wr(4'h0, 8'h01, 8'h0f);
        wr(4'h0, 8'h00, 8'h20);
        wr(4'h0, 8'h02, 8'h01);
        wr(4'h0, 8'h03, 8'h00);
        wr(4'h0, 8'h01, 8'h23);
        wr(4'h0, 8'h00, 8'h20);
        wr(4'h0, 8'h02, 8'h02);
        wr(4'h0, 8'h03, 8'h44);
        one(24'h202020, 24'h404040);
        PIX_HBLANK <= 1'b1;
        pix(24'h202020);
        PIX_HBLANK <= 1'b0;
        pix_idle();
        expect_pix(24'h202020);
        one(24'h202020, 24'h914040);
        wr(4'h0, 8'h01, 8'h00);
        // Whole codes leave no fraction, so no pattern may step them up
        for (i = 0; i < 8; i++) begin
            wr(4'ha, 8'h80, {3'b000, i[2:0], 2'b10});
            one(24'h4080fc, 24'h4080fc);
        end
        // Fractional table entries: pattern zero always steps a fraction up
        wr(4'h0, 8'h01, 8'h01);
        wr(4'ha, 8'h80, 8'h02);
        one(24'h101010, 24'h49d6d6);
        wr(4'ha, 8'h80, 8'h00);
        one(24'h101010, 24'h133636);
        // First frame start: frame count 1 shifts the 2x2 column per component
        wr(4'ha, 8'h80, 8'h04);
        PIX_FRAME_START <= 1'b1;
        pix(24'h101010);
        PIX_FRAME_START <= 1'b0;
        pix_idle();
        expect_pix(24'h123635);
        wr(4'h0, 8'h01, 8'h00);
        wr(4'ha, 8'h81, 8'h03);
        rd(4'ha, 8'h81, 8'h03);
        wr(4'ha, 8'h80, 8'h03);
        one(24'h5d01fe, 24'h5d01fe);
        stall <= 1'b1;
        fork
            for (i = 0; i < 40; i++) pix({i[7:0], ~i[7:0], 8'h33});
            begin
                wait (refused);
                repeat (20) @(posedge CLOCK);
                stall <= 1'b0;
            end
        join
        pix_idle();
        for (i = 0; i < 40; i++) expect_pix({i[7:0], ~i[7:0], 8'h33});
        check({23'h000000, refused}, 24'h000001, "full");
        stop_test();
    end
endmodule

/* File: verilog/colour_lut_dither.sv */
`timescale 1ns/1ps
module colour_lut_dither (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // Register port
    input  wire logic        REG_WE,
    input  wire logic        REG_RE,
    input  wire logic [3:0]  REG_PAGE,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    output logic      [7:0]  NEXT_SUBADDR,
    // Pixel input
    input  wire logic        PIX_VALID,
    output logic             PIX_READY,
    input  wire logic [7:0]  PIX_R,
    input  wire logic [7:0]  PIX_G,
    input  wire logic [7:0]  PIX_B,
    input  wire logic        PIX_LINE_START,
    input  wire logic        PIX_FRAME_START,
    input  wire logic        PIX_HBLANK,
    // Pixel output
    output logic             OUT_VALID,
    input  wire logic        OUT_READY,
    output logic      [7:0]  OUT_R,
    output logic      [7:0]  OUT_G,
    output logic      [7:0]  OUT_B
);
    localparam int CW = colour_pkg::COMP_W;
    localparam int LW = colour_pkg::LUT_W;
    localparam int NC = colour_pkg::NCOMP;

    // Register state
    logic [7:0]  position_q;
    logic [7:0]  control_q;
    logic [7:0]  upper_q;
    logic [7:0]  lower_q;
    logic [7:0]  dith_ctrl_q;
    logic [7:0]  dith_noise_q;
    logic [7:0]  dith_test0_q;
    logic [7:0]  dith_test1_q;
    logic [NC-1:0] wr_sel_q;
    logic [LW-1:0] wr_val_q;
    logic [7:0]  wr_pos_q;
    logic        pend_q;
    logic        wr_now;
    logic        lut_page;
    logic        dith_page;
    logic        wr_lower;

    // Pixel pipeline
    logic        adv;
    logic        take;
    logic        s1_valid_q;
    logic        s2_valid_q;
    logic        s1_byp_q;
    logic [CW-1:0] s1_raw_q [NC];
    logic [LW-1:0] s1_lut_q [NC];
    logic [7:0]  s1_x_q;
    logic [7:0]  s1_y_q;
    logic [7:0]  x_q;
    logic [7:0]  y_q;
    logic [7:0]  frame_q;
    logic [15:0] lfsr_q;
    logic [CW-1:0] dith_d [NC];
    logic [CW-1:0] s2_q [NC];
    logic [CW-1:0] pix_in [NC];
    logic        fifo_ready;
    logic [3*CW-1:0] fifo_out;

    assign lut_page  = REG_PAGE == colour_pkg::PAGE_LUT;
    assign dith_page = REG_PAGE == colour_pkg::PAGE_DITHER;
    assign wr_lower  = REG_WE && lut_page && REG_ADDR == colour_pkg::ADDR_LOWER;
    assign pix_in[0] = PIX_R;
    assign pix_in[1] = PIX_G;
    assign pix_in[2] = PIX_B;

    assign wr_now = pend_q && (!control_q[colour_pkg::CTL_HSYNCED] || PIX_HBLANK);

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            control_q    <= colour_pkg::CONTROL_RST;
            upper_q      <= '0;
            lower_q      <= '0;
            dith_ctrl_q  <= colour_pkg::DITH_CTRL_RST;
            dith_noise_q <= colour_pkg::DITH_NOISE_RST;
            dith_test0_q <= colour_pkg::DITH_TEST_RST;
            dith_test1_q <= colour_pkg::DITH_TEST_RST;
        end else if (REG_WE && lut_page) begin
            case (REG_ADDR)
                colour_pkg::ADDR_CONTROL: begin
                    control_q <= REG_WDATA;
                end
                colour_pkg::ADDR_UPPER: begin
                    upper_q <= REG_WDATA;
                end
                colour_pkg::ADDR_LOWER: begin
                    lower_q <= REG_WDATA;
                end
                default: begin
                end
            endcase
        end else if (REG_WE && dith_page) begin
            case (REG_ADDR)
                colour_pkg::ADDR_DITH_CTRL: begin
                    dith_ctrl_q <= REG_WDATA;
                end
                colour_pkg::ADDR_DITH_NOISE: begin
                    dith_noise_q <= REG_WDATA;
                end
                colour_pkg::ADDR_DITH_TEST0: begin
                    dith_test0_q <= REG_WDATA;
                end
                colour_pkg::ADDR_DITH_TEST1: begin
                    dith_test1_q <= REG_WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            position_q <= '0;
        end else if (REG_WE && lut_page && REG_ADDR == colour_pkg::ADDR_POSITION) begin
            position_q <= REG_WDATA;
        end else if (wr_lower) begin
            position_q <= position_q + 8'h01;
        end
    end

    // commit on low byte
    // A new low byte replaces one still waiting for blanking; host paces to a line.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            pend_q   <= 1'b0;
            wr_sel_q <= '0;
            wr_val_q <= '0;
            wr_pos_q <= '0;
        end else if (wr_lower) begin
            pend_q   <= 1'b1;
            wr_sel_q <= {control_q[colour_pkg::CTL_PROG_B],
                         control_q[colour_pkg::CTL_PROG_G],
                         control_q[colour_pkg::CTL_PROG_R]};
            wr_val_q <= {upper_q[LW-CW-1:0], REG_WDATA};
            wr_pos_q <= position_q;
        end else if (wr_now) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            NEXT_SUBADDR <= '0;
        end else if (wr_lower) begin
            NEXT_SUBADDR <= control_q[colour_pkg::CTL_QUICK] ? colour_pkg::ADDR_LOWER
                                                               : colour_pkg::ADDR_UPPER;
        end else if (REG_WE || REG_RE) begin
            NEXT_SUBADDR <= REG_ADDR + 8'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            REG_RDATA <= '0;
        end else if (REG_RE) begin
            REG_RDATA <= '0;
            if (lut_page) begin
                case (REG_ADDR)
                    colour_pkg::ADDR_POSITION: REG_RDATA <= position_q;
                    colour_pkg::ADDR_CONTROL:  REG_RDATA <= control_q;
                    colour_pkg::ADDR_UPPER:    REG_RDATA <= upper_q;
                    colour_pkg::ADDR_LOWER:    REG_RDATA <= lower_q;
                    default:                   REG_RDATA <= '0;
                endcase
            end else if (dith_page) begin
                case (REG_ADDR)
                    colour_pkg::ADDR_DITH_CTRL:  REG_RDATA <= dith_ctrl_q;
                    colour_pkg::ADDR_DITH_NOISE: REG_RDATA <= dith_noise_q;
                    colour_pkg::ADDR_DITH_TEST0: REG_RDATA <= dith_test0_q;
                    colour_pkg::ADDR_DITH_TEST1: REG_RDATA <= dith_test1_q;
                    default:                     REG_RDATA <= '0;
                endcase
            end
        end
    end

    // Whole pipe stalls together so the source sees back-pressure
    assign adv       = !s2_valid_q || fifo_ready;
    assign PIX_READY = adv;
    assign take      = PIX_VALID && adv;

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            s1_valid_q <= 1'b0;
            s2_valid_q <= 1'b0;
        end else if (adv) begin
            s1_valid_q <= PIX_VALID;
            s2_valid_q <= s1_valid_q;
        end
    end

    // Pixel position, first pixel of a line or frame carries the start flag
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            x_q <= '0;
            y_q <= '0;
        end else if (take) begin
            x_q <= PIX_LINE_START || PIX_FRAME_START ? 8'h01 : x_q + 8'h01;
            if (PIX_FRAME_START) begin
                y_q <= '0;
            end else if (PIX_LINE_START) begin
                y_q <= y_q + 8'h01;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            frame_q <= '0;
        end else if (take && PIX_FRAME_START) begin
            frame_q <= frame_q + 8'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            lfsr_q <= colour_pkg::LFSR_SEED;
        end else if (take) begin
            lfsr_q <= lfsr_q[0] ? (lfsr_q >> 1) ^ colour_pkg::LFSR_TAPS : lfsr_q >> 1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            s1_byp_q <= 1'b1;
            s1_x_q   <= '0;
            s1_y_q   <= '0;
        end else if (adv) begin
            s1_byp_q <= !control_q[colour_pkg::CTL_LOOKUP_EN] || wr_now;
            s1_x_q   <= PIX_LINE_START || PIX_FRAME_START ? 8'h00 : x_q;
            s1_y_q   <= PIX_FRAME_START ? 8'h00 : (PIX_LINE_START ? y_q + 8'h01 : y_q);
        end
    end

    genvar k;
    generate
        for (k = 0; k < NC; k++) begin : g_comp
            logic [LW-1:0] table_mem [colour_pkg::LUT_SIZE];
            logic [LW-1:0] v10;
            logic [LW:0]   sum;
            logic [LW-1:0] vn;
            logic [1:0]    noise;
            logic [3:0]    xa;
            logic [3:0]    ya;
            logic [5:0]    m5;
            logic [3:0]    thr;
            logic          inc;
            logic [7:0]    top;

            always_ff @(posedge CLOCK) begin
                if (wr_now && wr_sel_q[k]) begin
                    table_mem[wr_pos_q] <= wr_val_q;
                end
            end

            always_ff @(posedge CLOCK) begin
                if (!RSTN) begin
                    s1_raw_q[k] <= '0;
                    s1_lut_q[k] <= '0;
                end else if (adv) begin
                    s1_raw_q[k] <= pix_in[k];
                    s1_lut_q[k] <= table_mem[pix_in[k]];
                end
            end

            always_comb begin
                v10 = s1_byp_q ? {s1_raw_q[k], 2'b00} : s1_lut_q[k];
                noise = '0;
                if (dith_noise_q[colour_pkg::DN_ADD_NOISE]) begin
                    noise = dith_noise_q[colour_pkg::DN_NOISE_MAG]
                          ? lfsr_q[2*k+1 -: 2] : {1'b0, lfsr_q[2*k]};
                end
                sum = {1'b0, v10} + {9'h000, noise};
                vn  = sum[LW] ? '1 : sum[LW-1:0];
                xa  = 4'(s1_x_q[3:0] + frame_q[3:0] + 4'(k));
                ya  = 4'(s1_y_q[3:0] + {1'b0, frame_q[3:1]});
                m5  = 6'((xa + {ya, 1'b0}) % 5);
                if (dith_ctrl_q[colour_pkg::DC_PAT_LO+2]) begin
                    thr = lfsr_q[15-4*k -: 4];
                end else begin
                    case (colour_pkg::pattern_t'(dith_ctrl_q[colour_pkg::DC_PAT_LO +: 3]))
                        colour_pkg::PAT_ZERO:   thr = 4'h0;
                        colour_pkg::PAT_BAYER2:
                            thr = colour_pkg::BAYER4[{1'b0, ya[0], 1'b0, xa[0]}*4 +: 4];
                        colour_pkg::PAT_BAYER4:
                            thr = colour_pkg::BAYER4[{ya[1:0], xa[1:0]}*4 +: 4];
                        colour_pkg::PAT_SPEC5:  thr = 4'(m5 * 3);
                        default:                thr = 4'h0;
                    endcase
                end
                if (dith_ctrl_q[colour_pkg::DC_OUT8]) begin
                    inc = vn[1:0] > thr[3:2];
                    top = vn[9:2];
                    if (inc && top != 8'hff) begin
                        top = top + 8'h01;
                    end
                end else begin
                    inc = vn[3:0] > thr;
                    top = {2'b00, vn[9:4]};
                    if (inc && top != 8'h3f) begin
                        top = top + 8'h01;
                    end
                end
                if (dith_ctrl_q[colour_pkg::DC_BYPASS]) begin
                    top = dith_ctrl_q[colour_pkg::DC_OUT8] ? v10[9:2] : {2'b00, v10[9:4]};
                end
                dith_d[k] = top;
            end

            always_ff @(posedge CLOCK) begin
                if (!RSTN) begin
                    s2_q[k] <= '0;
                end else if (adv) begin
                    s2_q[k] <= dith_d[k];
                end
            end
        end
    endgenerate

    pixel_fifo #(
        .WIDTH (3*CW),
        .DEPTH (colour_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .rstn      (RSTN),
        .in_valid  (s2_valid_q),
        .in_ready  (fifo_ready),
        .in_data   ({s2_q[0], s2_q[1], s2_q[2]}),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (fifo_out)
    );

    assign OUT_R = fifo_out[3*CW-1 -: CW];
    assign OUT_G = fifo_out[2*CW-1 -: CW];
    assign OUT_B = fifo_out[CW-1:0];
endmodule

/* File: verilog/colour_pkg.sv */
// How it works
// - Each 8-bit colour component indexes its own 256-entry table of 10-bit values.
// - Only tables whose red, green or blue select bit is set take a write.
// - The assembled 10-bit entry is committed when the low byte is written.
// - The table position advances by one after each committed entry.
// - After a low byte write the next subaddress is 02H, or 03H with repeat set.
// - Pixels bypass the tables in a cycle where a table write takes place.
// - With blanking-only update set, table writes wait for horizontal blanking.
// - Lookup off gives the 8-bit component in the upper bits and two zero bits.
// - Table programming is accepted both with lookup off and during pixel flow.
// - Dither bypass 0 enables dithering; bypass 1 passes data unmodified.
// - Output codes vary over time; neighbouring pixels follow different sequences.
// - Pattern select: 000 zero, 001 2x2, 010 4x4, 011 5x5, 1XX random.
// - Noise enable adds one LSB of noise, or two when the amplitude bit is set.
// - Dither control registers sit at 80H to 83H of configuration page 10.
package colour_pkg;
    localparam int COMP_W   = 8;
    localparam int LUT_W    = 10;
    localparam int LUT_SIZE = 256;
    localparam int NCOMP    = 3;
    localparam int FIFO_DEPTH = 32;

    // Pages
    localparam logic [3:0] PAGE_LUT    = 4'h0;
    localparam logic [3:0] PAGE_DITHER = 4'ha;

    // Table page subaddresses
    localparam logic [7:0] ADDR_POSITION = 8'h00;
    localparam logic [7:0] ADDR_CONTROL  = 8'h01;
    localparam logic [7:0] ADDR_UPPER    = 8'h02;
    localparam logic [7:0] ADDR_LOWER    = 8'h03;

    // Dither page subaddresses
    localparam logic [7:0] ADDR_DITH_CTRL  = 8'h80;
    localparam logic [7:0] ADDR_DITH_NOISE = 8'h81;
    localparam logic [7:0] ADDR_DITH_TEST0 = 8'h82;
    localparam logic [7:0] ADDR_DITH_TEST1 = 8'h83;

    // Control fields
    localparam int CTL_LOOKUP_EN  = 0;
    localparam int CTL_PROG_R     = 1;
    localparam int CTL_PROG_G     = 2;
    localparam int CTL_PROG_B     = 3;
    localparam int CTL_QUICK      = 4;
    localparam int CTL_HSYNCED    = 5;
    localparam int DC_BYPASS      = 0;
    localparam int DC_OUT8        = 1;
    localparam int DC_PAT_LO      = 2;
    localparam int DN_ADD_NOISE   = 0;
    localparam int DN_NOISE_MAG   = 1;

    // Reset values
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic [7:0]  DITH_CTRL_RST = 8'h01;
    localparam logic [7:0]  DITH_NOISE_RST = 8'h00;
    localparam logic [7:0]  DITH_TEST_RST = 8'h00;
    localparam logic [15:0] LFSR_SEED     = 16'hace1;
    localparam logic [15:0] LFSR_TAPS     = 16'hb400;

    // Bayer 4x4 thresholds, entry {y[1:0],x[1:0]} at nibble index
    localparam logic [63:0] BAYER4 = 64'h5d7f_91b3_6e4c_a280;

    typedef enum logic [2:0] {
        PAT_ZERO   = 3'b000,
        PAT_BAYER2 = 3'b001,
        PAT_BAYER4 = 3'b010,
        PAT_SPEC5  = 3'b011
    } pattern_t;
endpackage

/* File: verilog/pixel_fifo.sv */
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule
